/* logic/lfdl_pkg.sv */
// Constants for the legacy T1 link byte buffers
package lfdl_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_RX_BYTE = 8'hC0;
    localparam logic [7:0] ADDR_TX_BYTE = 8'hC1;
    localparam logic [7:0] ADDR_MATCH1 = 8'hC2;
    localparam logic [7:0] ADDR_MATCH2 = 8'hC3;
    localparam logic [7:0] ADDR_STATUS = 8'hC4;
    localparam logic [7:0] ADDR_MASK = 8'hC5;
    localparam logic [7:0] ADDR_RCR2 = 8'hC6;
    localparam logic [7:0] ADDR_TCR2 = 8'hC7;
    localparam logic [7:0] ADDR_TCR1 = 8'hC8;
    // Field positions
    localparam int ST_MATCH = 1;
    localparam int ST_EMPTY = 2;
    localparam int ST_FULL = 3;
    localparam int RCR2_DESTUFF = 3;
    localparam int TCR2_STUFF = 5;
    localparam int TCR2_MF_LOAD = 6;
    localparam int TCR1_FS_SRC = 2;
    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    // Counts
    localparam logic [2:0] ONES_LIMIT = 3'h5;
    localparam logic [2:0] ONES_SAT = 3'h6;
    localparam logic [2:0] LAST_BIT = 3'h7;
endpackage

/* logic/lfdl_rx_destuff.sv */
// Receive zero destuffer for the link bit stream
`timescale 1ns/1ps
module lfdl_rx_destuff
    import lfdl_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Link bit in
    input wire logic bit_en,
    input wire logic bit_in,
    input wire logic enable,
    // Keep decision for this bit
    output logic keep
);
    logic [2:0] run_q; // Saturating count of ones in a row

    // Drop only a zero after exactly five ones
    always_comb begin
        keep = !(enable && !bit_in && run_q == ONES_LIMIT);
    end

    // Count ones, saturating so long runs stay distinct
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_q <= 3'h0;
        end else if (bit_en) begin
            if (!bit_in) begin
                run_q <= 3'h0;
            end else if (run_q != ONES_SAT) begin
                run_q <= run_q + 3'h1;
            end
        end
    end

    a_drop_five: assert property (@(posedge core_clk) disable iff (!rst_b)
        (bit_en && enable && !bit_in && run_q == ONES_LIMIT) |-> !keep)
        else $error("zero after five ones not dropped");
    a_keep_six: assert property (@(posedge core_clk) disable iff (!rst_b)
        (bit_en && !bit_in && run_q == ONES_SAT) |-> keep)
        else $error("zero after six ones dropped");
    // Long runs must stay at the ceiling so the zero after them is kept
    a_run_sat: assert property (@(posedge core_clk) disable iff (!rst_b)
        (bit_en && bit_in && run_q == ONES_SAT) |=> run_q == ONES_SAT)
        else $error("ones count left its ceiling");
endmodule

/* logic/lfdl_core.sv */
// Legacy T1 link byte buffers with stuffing and match detection
`timescale 1ns/1ps
module lfdl_core
    import lfdl_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Host register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic int_b,
    // Receive link bits from framer
    input wire logic rx_link_en,
    input wire logic rx_link_bit,
    // Transmit link slots from framer
    input wire logic d4_mode,
    input wire logic tx_slot,
    input wire logic tx_mf_start,
    output logic tx_link_bit,
    output logic fs_from_reg
);
    logic [7:0] rx_byte_q; // Completed receive byte
    logic [7:0] rx_sh_q; // Receive shifter
    logic [2:0] rx_cnt_q; // Bits in receive shifter
    logic [7:0] tx_byte_q; // Transmit link byte
    logic [7:0] tx_sh_q; // Transmit shifter
    logic [2:0] tx_cnt_q; // Bits sent of current byte
    logic [2:0] tx_ones_q; // Ones sent in a row
    logic [7:0] match1_q; // First match byte
    logic [7:0] match2_q; // Second match byte
    logic [7:0] status_q; // Sticky status flags
    logic [7:0] mask_q; // Interrupt mask
    logic [7:0] rcr2_q; // Receive control
    logic [7:0] tcr2_q; // Transmit control two
    logic [7:0] tcr1_q; // Transmit control one
    logic rx_keep; // Bit survives destuffing
    logic rx_take; // Bit enters shifter
    logic rx_done; // Byte completes this cycle
    logic [7:0] rx_next; // Shifter after this bit
    logic tx_stuff; // Slot carries a stuffed zero
    logic tx_load_ok; // Register may load at byte start
    logic [7:0] tx_src; // Byte the slot sends from
    logic tx_bit; // Bit sent this slot
    logic tx_done; // Last bit of byte leaves

    // Destuffer on the received link bits
    lfdl_rx_destuff u_destuff (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .bit_en(rx_link_en),
        .bit_in(rx_link_bit),
        .enable(rcr2_q[RCR2_DESTUFF]),
        .keep(rx_keep)
    );

    // Receive shift decode, LSB arrives first
    always_comb begin
        rx_take = rx_link_en && rx_keep;
        rx_next = {rx_link_bit, rx_sh_q[7:1]};
        rx_done = rx_take && rx_cnt_q == LAST_BIT;
    end

    // Receive shifter and byte register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_sh_q <= REG_RESET;
            rx_cnt_q <= 3'h0;
            rx_byte_q <= REG_RESET;
        end else if (rx_take) begin
            rx_sh_q <= rx_next;
            rx_cnt_q <= rx_cnt_q + 3'h1;
            if (rx_done) begin
                rx_byte_q <= rx_next;
            end
        end
    end

    // Transmit slot decode
    always_comb begin
        tx_stuff = tcr2_q[TCR2_STUFF] && tx_ones_q == ONES_LIMIT;
        // D4 with multiframe load waits for the boundary
        tx_load_ok = !(d4_mode && tcr2_q[TCR2_MF_LOAD]) || tx_mf_start;
        tx_src = (tx_cnt_q == 3'h0 && tx_load_ok) ? tx_byte_q : tx_sh_q;
        tx_bit = tx_stuff ? 1'b0 : tx_src[0];
        tx_done = tx_slot && !tx_stuff && tx_cnt_q == LAST_BIT;
    end

    // Transmit shifter, rotates so an unrefreshed byte repeats
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_sh_q <= REG_RESET;
            tx_cnt_q <= 3'h0;
            tx_ones_q <= 3'h0;
            tx_link_bit <= 1'b0;
        end else if (tx_slot) begin
            tx_link_bit <= tx_bit;
            if (tx_stuff) begin
                tx_ones_q <= 3'h0;
            end else begin
                tx_sh_q <= {tx_src[0], tx_src[7:1]};
                tx_cnt_q <= tx_cnt_q + 3'h1;
                tx_ones_q <= tx_src[0] ? tx_ones_q + 3'h1 : 3'h0;
            end
        end
    end

    // Host writes to control and data registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_byte_q <= REG_RESET;
            match1_q <= REG_RESET;
            match2_q <= REG_RESET;
            mask_q <= REG_RESET;
            rcr2_q <= REG_RESET;
            tcr2_q <= REG_RESET;
            tcr1_q <= REG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_TX_BYTE: tx_byte_q <= reg_wdata;
                ADDR_MATCH1: match1_q <= reg_wdata;
                ADDR_MATCH2: match2_q <= reg_wdata;
                ADDR_MASK: mask_q <= reg_wdata;
                ADDR_RCR2: rcr2_q <= reg_wdata;
                ADDR_TCR2: tcr2_q <= reg_wdata;
                ADDR_TCR1: tcr1_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Sticky flags, write one to clear, a set wins over a clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= REG_RESET;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (reg_wr && reg_addr == ADDR_STATUS && reg_wdata[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
            if (rx_done) begin
                status_q[ST_FULL] <= 1'b1;
            end
            if (rx_done && (rx_next == match1_q || rx_next == match2_q)) begin
                status_q[ST_MATCH] <= 1'b1;
            end
            if (tx_done) begin
                status_q[ST_EMPTY] <= 1'b1;
            end
        end
    end

    // Interrupt held low while any unmasked flag stands
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            int_b <= 1'b1;
        end else begin
            int_b <= ~|(status_q & mask_q);
        end
    end

    // Fs source select pin, one means from the transmit byte
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fs_from_reg <= 1'b1;
        end else begin
            fs_from_reg <= !tcr1_q[TCR1_FS_SRC];
        end
    end

    // Registered read data, unmapped reads zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= REG_RESET;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_RX_BYTE: reg_rdata <= rx_byte_q;
                ADDR_TX_BYTE: reg_rdata <= tx_byte_q;
                ADDR_MATCH1: reg_rdata <= match1_q;
                ADDR_MATCH2: reg_rdata <= match2_q;
                ADDR_STATUS: reg_rdata <= status_q;
                ADDR_MASK: reg_rdata <= mask_q;
                ADDR_RCR2: reg_rdata <= rcr2_q;
                ADDR_TCR2: reg_rdata <= tcr2_q;
                ADDR_TCR1: reg_rdata <= tcr1_q;
                default: reg_rdata <= REG_RESET;
            endcase
        end
    end

    // Checks on the main behaviour
    a_full_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        rx_done |=> status_q[ST_FULL] && rx_byte_q == $past(rx_next))
        else $error("full flag or byte missing after completion");
    a_match_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (rx_done && rx_next == match2_q) |=> status_q[ST_MATCH])
        else $error("match flag not set");
    a_int_level: assert property (@(posedge core_clk) disable iff (!rst_b)
        (status_q[ST_FULL] && mask_q[ST_FULL]) |=> !int_b)
        else $error("interrupt not low for unmasked full");
    a_flag_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        (status_q[ST_EMPTY] && !(reg_wr && reg_addr == ADDR_STATUS)) |=>
        status_q[ST_EMPTY])
        else $error("empty flag dropped without acknowledge");
    a_empty_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tx_slot && !tx_stuff && tx_cnt_q == LAST_BIT) |=> status_q[ST_EMPTY])
        else $error("empty flag not set after eighth bit");
    a_stuff_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tx_slot && tcr2_q[TCR2_STUFF] && tx_ones_q == ONES_LIMIT) |=>
        !tx_link_bit && tx_ones_q == 3'h0)
        else $error("no zero stuffed after five ones");
    a_tx_lsb: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tx_slot && !tx_stuff && tx_cnt_q == 3'h0 && tx_load_ok) |=>
        tx_link_bit == $past(tx_byte_q[0]))
        else $error("byte not started with its LSB");
    a_mf_wait: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tx_slot && !tx_stuff && tx_cnt_q == 3'h0 && d4_mode && tcr2_q[TCR2_MF_LOAD]
        && !tx_mf_start) |=> tx_link_bit == $past(tx_sh_q[0]))
        else $error("register loaded off a multiframe boundary");
    c_rx_match: cover property (@(posedge core_clk) rx_done && rx_next == match1_q);
    c_tx_stuff: cover property (@(posedge core_clk) tx_slot && tx_stuff);
    c_tx_repeat: cover property (@(posedge core_clk) tx_done ##[1:200] tx_done);
    c_rx_drop: cover property (@(posedge core_clk) rx_link_en && !rx_keep);
endmodule

/* dv/lfdl_framer_model.sv */
// Framer-side model that offers received link bits and transmit slots
`timescale 1ns/1ps
module lfdl_framer_model (
    // Clock
    input wire logic core_clk,
    // Link traffic toward the core
    output logic rx_link_en,
    output logic rx_link_bit,
    output logic tx_slot,
    output logic tx_mf_start,
    // Transmit bit from the core
    input wire logic tx_link_bit
);
    // Idle values at time zero
    initial begin
        rx_link_en = 1'b0;
        rx_link_bit = 1'b0;
        tx_slot = 1'b0;
        tx_mf_start = 1'b0;
    end

    // Send n received link bits, first bit first, idle cycle between
    task automatic rx_bits(input logic [15:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            rx_link_en = 1'b1;
            rx_link_bit = b[i];
            @(negedge core_clk);
            rx_link_en = 1'b0;
            // Idle line shows the inverse so no stale bit can be reused
            rx_link_bit = ~b[i];
        end
    endtask

    // Offer one transmit slot and return the bit placed in it
    task automatic tx_take(input logic mf, output logic b);
        @(negedge core_clk);
        tx_slot = 1'b1;
        tx_mf_start = mf;
        @(negedge core_clk);
        tx_slot = 1'b0;
        tx_mf_start = 1'b0;
        b = tx_link_bit;
    endtask
endmodule

/* dv/testbench.sv */
// Self-checking bench for the legacy link byte buffers
`timescale 1ns/1ps
module testbench;
    import lfdl_pkg::*;
    logic core_clk, rst_b, reg_wr, reg_rd, int_b, fs_from_reg, d4_mode;
    logic rx_link_en, rx_link_bit, tx_slot, tx_mf_start, tx_link_bit;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, got;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;

    lfdl_core i_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .int_b(int_b), .rx_link_en(rx_link_en),
        .rx_link_bit(rx_link_bit), .d4_mode(d4_mode), .tx_slot(tx_slot),
        .tx_mf_start(tx_mf_start), .tx_link_bit(tx_link_bit),
        .fs_from_reg(fs_from_reg));
    lfdl_framer_model i_frm (.core_clk(core_clk), .rx_link_en(rx_link_en),
        .rx_link_bit(rx_link_bit), .tx_slot(tx_slot),
        .tx_mf_start(tx_mf_start), .tx_link_bit(tx_link_bit));

    // 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Cut a hang short
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            test_done();
        end
    end

    task automatic test_done();
        if (n_fail == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    // One-cycle read strobe, data taken once registered
    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    // Eight slots, multiframe mark on the first
    task automatic tx_byte(input logic mf, output logic [7:0] g);
        for (int i = 0; i < 8; i++) i_frm.tx_take(mf && i == 0, g[i]);
    endtask

    // Full flag, interrupt and acknowledge
    task automatic t_rx_full();
        wr(ADDR_MASK, 8'h08);
        i_frm.rx_bits(16'h00A5, 8);
        rdr(ADDR_RX_BYTE, rd); // Host reads well before the next byte
        chk("rx byte", rd, 8'hA5);
        // Receive byte is read only, a write must not disturb it
        wr(ADDR_RX_BYTE, 8'h5A);
        rdr(ADDR_RX_BYTE, rd);
        chk("rx byte read only", rd, 8'hA5);
        rdr(ADDR_STATUS, rd);
        chk("rx full", rd, 8'h08);
        chk("int low", {7'h00, int_b}, 8'h00);
        rdr(ADDR_STATUS, rd);
        chk("flag held", rd, 8'h08);
        wr(ADDR_STATUS, 8'h08);
        @(negedge core_clk);
        chk("int released", {7'h00, int_b}, 8'h01);
    endtask
    // Match against both match bytes
    task automatic t_match();
        wr(ADDR_MASK, 8'h02);
        wr(ADDR_MATCH1, 8'h3C);
        wr(ADDR_MATCH2, 8'hC3);
        rdr(ADDR_MATCH2, rd);
        chk("match two reg", rd, 8'hC3);
        // Unmapped read right after a nonzero one must give zero
        rdr(8'hF0, rd);
        chk("unmapped", rd, 8'h00);
        i_frm.rx_bits(16'h003C, 8);
        rdr(ADDR_STATUS, rd);
        chk("match one", rd, 8'h0A);
        chk("match int", {7'h00, int_b}, 8'h00);
        wr(ADDR_STATUS, 8'hFF);
        i_frm.rx_bits(16'h00C3, 8);
        rdr(ADDR_STATUS, rd);
        chk("match two", rd, 8'h0A);
        wr(ADDR_STATUS, 8'hFF);
        i_frm.rx_bits(16'h0055, 8);
        rdr(ADDR_STATUS, rd);
        chk("no match", rd, 8'h08);
        wr(ADDR_STATUS, 8'hFF);
    endtask
    // Destuffer removes zero after five ones, keeps it after six
    task automatic t_destuff();
        wr(ADDR_RCR2, 8'h08); // Destuffing on for link extraction
        i_frm.rx_bits(16'h001F, 9);
        rdr(ADDR_RX_BYTE, rd);
        chk("destuffed", rd, 8'h1F);
        i_frm.rx_bits(16'h003F, 8);
        rdr(ADDR_RX_BYTE, rd);
        chk("six ones kept", rd, 8'h3F);
        wr(ADDR_STATUS, 8'hFF);
    endtask
    // Serial send, empty flag, repeat without rewrite
    task automatic t_tx();
        wr(ADDR_MASK, 8'h04);
        wr(ADDR_TX_BYTE, 8'h96);
        tx_byte(1'b0, got);
        chk("tx bits", got, 8'h96);
        rdr(ADDR_STATUS, rd);
        chk("tx empty", rd, 8'h04);
        chk("empty int", {7'h00, int_b}, 8'h00);
        wr(ADDR_STATUS, 8'h04);
        tx_byte(1'b0, got);
        chk("tx repeat", got, 8'h96);
    endtask
    // D4 load only on multiframe boundary
    task automatic t_d4();
        d4_mode = 1'b1;
        wr(ADDR_TCR1, 8'h04);
        // Select pin is registered, so let one more edge pass
        @(negedge core_clk);
        chk("fs from pin", {7'h00, fs_from_reg}, 8'h00);
        wr(ADDR_TCR1, 8'h00); // Fs taken from the transmit byte
        @(negedge core_clk);
        chk("fs source", {7'h00, fs_from_reg}, 8'h01);
        wr(ADDR_TCR2, 8'h40); // Load on multiframe
        wr(ADDR_TX_BYTE, 8'h1C); // Fs pattern
        tx_byte(1'b0, got);
        chk("held off", got, 8'h96);
        tx_byte(1'b1, got);
        chk("fs pattern", got, 8'h1C);
        d4_mode = 1'b0;
    endtask
    // Stuffer inserts zero after five ones
    task automatic t_stuff();
        wr(ADDR_TCR2, 8'h20); // Stuffing on for link insertion
        wr(ADDR_TX_BYTE, 8'hFF); // Written in time to avoid repeat
        tx_byte(1'b0, got);
        chk("stuffed", got, 8'hDF);
    endtask

    // Main sequence
    initial begin
        rst_b = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        d4_mode = 1'b0;
        repeat (8) @(negedge core_clk);
        rst_b = 1'b1;
        chk("int reset", {7'h00, int_b}, 8'h01);
        rdr(ADDR_MASK, rd);
        chk("mask reset", rd, REG_RESET);
        t_rx_full();
        t_match();
        t_destuff();
        t_tx();
        t_d4();
        t_stuff();
        test_done();
    end
endmodule
